// file: inc/pic_pkg.sv
// Constants shared by the priority interrupt controller files.
// Operation
// - Each two-source group gets its own level from two priority bits.
// - A running routine is preempted only by a strictly higher level; the wake-up call here preempts at any level.
// - Among pending levels the highest one is chosen.
// - Equal levels: groups 1 to 6 in order, first member first.
// - Flags captured at state5_phase2 and polled in the next machine cycle; here at mc_end of the same machine cycle.
// - An unblocked captured request makes the core do a hardware long call.
// - No call while equal/higher level runs, mid-instruction, or on return; the wake-up call here skips the level check.
// - After return or enable/priority write, one more instruction runs first.
// - Blocked requests are not remembered; each poll sees current flags.
// - Higher request before C3 sample point is vectored in C5 and C6.
// - Call pushes program counter only, then loads the vector address.
// - Each source has its fixed vector address, wake-up at 007B.
// - Return from interrupt clears the current in-service level.
// - Plain subroutine return leaves in-service status untouched.
// - External 0 and 1 flags cleared on vectoring only in edge mode.
// - Trigger type 0 requests on low level, 1 on high-then-low samples.
// - External 4, 5, 6 flags set only on rising pin transitions.
// - Timer 2 reload flag set on falling trigger edge when enabled.
// - Edge external flags cleared by hardware on routine entry.
// - Level code is high bit then low bit, 00 lowest, 11 highest.
// - Serial and timer 2 flags are never cleared on vectoring.
// - Software flag writes act like hardware, except level-mode ext 0/1.
package pic_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_EN_A    = 8'h00;
  localparam logic [7:0] OFS_EN_B    = 8'h04;
  localparam logic [7:0] OFS_PRIO_LO = 8'h08;
  localparam logic [7:0] OFS_PRIO_HI = 8'h0C;
  localparam logic [7:0] OFS_FLAG_A  = 8'h10;
  localparam logic [7:0] OFS_FLAG_B  = 8'h14;
  localparam logic [7:0] OFS_CTRL    = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;

  localparam logic [7:0] EN_RST   = 8'h00;
  localparam logic [5:0] PRIO_RST = 6'h00;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam int         EN_GLOBAL = 7;

  // ----------------------------------------------------------------
  // Control bits and request flag positions
  // ----------------------------------------------------------------
  localparam int CTL_IT0   = 0;
  localparam int CTL_IT1   = 1;
  localparam int CTL_TIMER2_EXT_RELOAD_ENABLE = 2;

  localparam int FLG_E0   = 0;
  localparam int FLG_E1   = 1;
  localparam int FLG_T0   = 2;
  localparam int FLG_T1   = 3;
  localparam int FLG_RI   = 4;
  localparam int FLG_TI   = 5;
  localparam int FLG_TF2  = 6;
  localparam int FLG_TIMER2_EXT_RELOAD_FLAG = 7;
  localparam int FLG_ADC  = 8;
  localparam int FLG_SWI  = 9;
  localparam int FLG_E3   = 10;
  localparam int FLG_E4   = 11;
  localparam int FLG_E5   = 12;
  localparam int FLG_E6   = 13;
  localparam int FLG_WK   = 14;

  // ----------------------------------------------------------------
  // Polling order, vectors and clearing
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_TABLE [0:11] = '{
    16'h0003, 16'h0043, 16'h000B, 16'h004B, 16'h0013, 16'h0053,
    16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h002B, 16'h006B};
  localparam logic [15:0] VEC_WAKE = 16'h007B;
  localparam logic [3:0] POLL_FLAG [0:11] = '{
    4'h0, 4'h8, 4'h2, 4'h9, 4'h1, 4'hA, 4'h3, 4'hB, 4'h4, 4'hC, 4'h6, 4'hD};
  localparam logic [11:0] POLL_HWCLR = 12'hAFD;

  // ----------------------------------------------------------------
  // Machine cycle timing in oscillator periods
  // ----------------------------------------------------------------
  localparam logic [3:0] MCYC_LEN = 4'hC;
  localparam logic [3:0] STATE5_PHASE2_SAMPLE_POINT_AT  = 4'h9;
  localparam logic [3:0] MCEND_AT = 4'hB;

endpackage : pic_pkg

// file: hdl/pic_pinsync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ns
`default_nettype none
module pic_pinsync #(
  parameter int W = 6
) (
  input  wire logic         CLOCK,
  input  wire logic         RST_N,
  input  wire logic [W-1:0] pin_i,
  output var  logic [W-1:0] lvl_o
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);
  wire  [W-1:0] nxt_lvl = (agree & s3_ff) | (~agree & lvl_o);

  // Pins idle high, so reset to ones to avoid a false falling edge
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
      lvl_o <= '1;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_o <= nxt_lvl;
    end
  end

endmodule : pic_pinsync
`default_nettype wire

// file: hdl/pic_mcycle.sv
// Machine cycle divider: sample point and cycle end strobes.
`timescale 1ns/1ns
`default_nettype none
module pic_mcycle #(
  parameter logic [3:0] LEN   = pic_pkg::MCYC_LEN,
  parameter logic [3:0] S5_AT = pic_pkg::STATE5_PHASE2_SAMPLE_POINT_AT,
  parameter logic [3:0] END_AT = pic_pkg::MCEND_AT
) (
  input  wire logic CLOCK,
  input  wire logic RST_N,
  output var  logic state5_phase2_sample_point_o,
  output var  logic mc_end_o
);

  logic [3:0] phase_ff;
  wire  [3:0] nxt_phase = (phase_ff == LEN - 4'h1) ? 4'h0
                                                   : phase_ff + 4'h1;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      phase_ff <= 4'h0;
      state5_phase2_sample_point_o   <= 1'b0;
      mc_end_o <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      state5_phase2_sample_point_o   <= (nxt_phase == S5_AT);
      mc_end_o <= (nxt_phase == END_AT);
    end
  end

endmodule : pic_mcycle
`default_nettype wire

// file: hdl/pic_ctrl.sv
// Priority interrupt controller with classic Wishbone register slave.
`timescale 1ns/1ns
`default_nettype none
module pic_ctrl #(
  parameter int NSRC = 12
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output var  logic [31:0] WB_DAT_O,
  output var  logic        WB_ACK_O,
  input  wire logic        LAST_CYCLE,
  input  wire logic        RETURN_FROM_INTERRUPT_EXEC,
  input  wire logic        EXT0_PIN,
  input  wire logic        EXT1_PIN,
  input  wire logic        EXT4_PIN,
  input  wire logic        EXT5_PIN,
  input  wire logic        EXT6_PIN,
  input  wire logic        TIMER2_RELOAD_TRIGGER_PIN_PIN,
  input  wire logic        TMR0_OVF,
  input  wire logic        TMR1_OVF,
  input  wire logic        TMR2_OVF,
  input  wire logic        SER_RX_DONE,
  input  wire logic        SER_TX_DONE,
  input  wire logic        ADC_DONE,
  input  wire logic        EXT3_EVT,
  input  wire logic        WAKE_EVT,
  output var  logic        HARDWARE_LONG_CALL_REQ,
  output var  logic [15:0] HARDWARE_LONG_CALL_VEC,
  output var  logic        MC_END
);

  // ----------------------------------------------------------------
  // Timing and pins
  // ----------------------------------------------------------------
  logic       state5_phase2_sample_point_w;
  logic       mc_end_w;
  logic [5:0] pin_s;
  logic [5:0] smp_ff;

  pic_mcycle u_mcycle (
    .CLOCK    (CLOCK),
    .RST_N    (RST_N),
    .state5_phase2_sample_point_o   (state5_phase2_sample_point_w),
    .mc_end_o (mc_end_w)
  );

  pic_pinsync #(.W(6)) u_pinsync (
    .CLOCK (CLOCK),
    .RST_N (RST_N),
    .pin_i ({TIMER2_RELOAD_TRIGGER_PIN_PIN, EXT6_PIN, EXT5_PIN, EXT4_PIN, EXT1_PIN, EXT0_PIN}),
    .lvl_o (pin_s)
  );

  // Edges compare two successive per-machine-cycle samples
  wire [5:0] fall = smp_ff & ~pin_s;
  wire [5:0] rise = ~smp_ff & pin_s;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]      en_a_ff;
  logic [5:0]      en_b_ff;
  logic [5:0]      prio_lo_ff;
  logic [5:0]      prio_hi_ff;
  logic [2:0]      ctl_ff;
  logic [14:0]     flg_ff;
  logic [NSRC:0]   cap_ff;
  logic [3:0]      insvc_ff;
  logic            blk_ff;
  logic            ack_ff;
  logic [31:0]     rd_ff;
  logic            hardware_long_call_ff;
  logic [15:0]     vec_ff;

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  wire req_on = WB_CYC_I & WB_STB_I;
  wire wr_go  = req_on & WB_WE_I & ack_ff & WB_SEL_I[0];
  wire [7:0] adr = {WB_ADR_I[7:2], 2'b00};
  wire wr_ea  = wr_go & (adr == pic_pkg::OFS_EN_A);
  wire wr_eb  = wr_go & (adr == pic_pkg::OFS_EN_B);
  wire wr_pl  = wr_go & (adr == pic_pkg::OFS_PRIO_LO);
  wire wr_ph  = wr_go & (adr == pic_pkg::OFS_PRIO_HI);
  wire wr_fa  = wr_go & (adr == pic_pkg::OFS_FLAG_A);
  wire wr_fb  = wr_go & (adr == pic_pkg::OFS_FLAG_B);
  wire wr_ct  = wr_go & (adr == pic_pkg::OFS_CTRL);
  wire wr_ctl = wr_ea | wr_eb | wr_pl | wr_ph;

  // Unmapped offsets read as zero and ignore writes
  wire [7:0] rd_val =
    (adr == pic_pkg::OFS_EN_A)    ? en_a_ff :
    (adr == pic_pkg::OFS_EN_B)    ? {2'b00, en_b_ff} :
    (adr == pic_pkg::OFS_PRIO_LO) ? {2'b00, prio_lo_ff} :
    (adr == pic_pkg::OFS_PRIO_HI) ? {2'b00, prio_hi_ff} :
    (adr == pic_pkg::OFS_FLAG_A)  ? flg_ff[7:0] :
    (adr == pic_pkg::OFS_FLAG_B)  ? {1'b0, flg_ff[14:8]} :
    (adr == pic_pkg::OFS_CTRL)    ? {5'h00, ctl_ff} :
    (adr == pic_pkg::OFS_STATUS)  ? {4'h0, insvc_ff} : 8'h00;

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  wire it0 = ctl_ff[pic_pkg::CTL_IT0];
  wire it1 = ctl_ff[pic_pkg::CTL_IT1];
  logic [14:0] hs;
  logic [14:0] hc;
  logic        grant;
  logic        wk_go;
  logic [3:0]  win_idx;

  assign hs[pic_pkg::FLG_E0]   = state5_phase2_sample_point_w & it0 & fall[0];
  assign hs[pic_pkg::FLG_E1]   = state5_phase2_sample_point_w & it1 & fall[1];
  assign hs[pic_pkg::FLG_T0]   = TMR0_OVF;
  assign hs[pic_pkg::FLG_T1]   = TMR1_OVF;
  assign hs[pic_pkg::FLG_RI]   = SER_RX_DONE;
  assign hs[pic_pkg::FLG_TI]   = SER_TX_DONE;
  assign hs[pic_pkg::FLG_TF2]  = TMR2_OVF;
  assign hs[pic_pkg::FLG_TIMER2_EXT_RELOAD_FLAG] = state5_phase2_sample_point_w & fall[5] &
                                 ctl_ff[pic_pkg::CTL_TIMER2_EXT_RELOAD_ENABLE];
  assign hs[pic_pkg::FLG_ADC]  = ADC_DONE;
  assign hs[pic_pkg::FLG_SWI]  = 1'b0;
  assign hs[pic_pkg::FLG_E3]   = EXT3_EVT;
  assign hs[pic_pkg::FLG_E4]   = state5_phase2_sample_point_w & rise[2];
  assign hs[pic_pkg::FLG_E5]   = state5_phase2_sample_point_w & rise[3];
  assign hs[pic_pkg::FLG_E6]   = state5_phase2_sample_point_w & rise[4];
  assign hs[pic_pkg::FLG_WK]   = WAKE_EVT;

  // Serial, timer 2 and converter carry no clear in the table
  wire clr_hit = grant & pic_pkg::POLL_HWCLR[win_idx];
  wire [14:0] clr_one = 15'h0001 << pic_pkg::POLL_FLAG[win_idx];
  assign hc = (clr_hit ? clr_one : 15'h0000) |
              {wk_go, 14'h0000};

  // Software writes act as hardware would; a set still wins
  wire [14:0] sw_msk = {{7{wr_fb}}, {8{wr_fa}}};
  wire [14:0] sw_val = {WB_DAT_I[6:0], WB_DAT_I[7:0]};
  wire [14:0] base_flg = hs | (sw_msk & sw_val) |
                         (~sw_msk & flg_ff & ~hc);

  // Level mode follows the pin only; writes and clears have no effect
  wire lvl0 = state5_phase2_sample_point_w ? ~pin_s[0] : flg_ff[pic_pkg::FLG_E0];
  wire lvl1 = state5_phase2_sample_point_w ? ~pin_s[1] : flg_ff[pic_pkg::FLG_E1];
  wire [14:0] nxt_flg = {base_flg[14:2],
                         it1 ? base_flg[1] : lvl1,
                         it0 ? base_flg[0] : lvl0};

  // ----------------------------------------------------------------
  // Capture in polling order, grouped in pairs
  // ----------------------------------------------------------------
  wire [NSRC:0] nxt_cap = {
    nxt_flg[pic_pkg::FLG_WK],  nxt_flg[pic_pkg::FLG_E6],
    nxt_flg[pic_pkg::FLG_TF2] | nxt_flg[pic_pkg::FLG_TIMER2_EXT_RELOAD_FLAG],
    nxt_flg[pic_pkg::FLG_E5],
    nxt_flg[pic_pkg::FLG_RI] | nxt_flg[pic_pkg::FLG_TI],
    nxt_flg[pic_pkg::FLG_E4],  nxt_flg[pic_pkg::FLG_T1],
    nxt_flg[pic_pkg::FLG_E3],  nxt_flg[pic_pkg::FLG_E1],
    nxt_flg[pic_pkg::FLG_SWI], nxt_flg[pic_pkg::FLG_T0],
    nxt_flg[pic_pkg::FLG_ADC], nxt_flg[pic_pkg::FLG_E0]};

  wire gen_en = en_a_ff[pic_pkg::EN_GLOBAL];
  logic [NSRC-1:0] req;

  for (genvar i = 0; i < NSRC; i++) begin : g_req
    if (i % 2 == 0) begin : g_first
      assign req[i] = cap_ff[i] & en_a_ff[i/2] & gen_en;
    end else begin : g_second
      assign req[i] = cap_ff[i] & en_b_ff[i/2] & gen_en;
    end
  end

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  logic       win_ok;
  logic [1:0] win_lvl;
  logic [2:0] cur_lvl;

  // Downward scan with >= leaves the lowest index of the top level
  always_comb begin
    win_ok  = 1'b0;
    win_idx = 4'h0;
    win_lvl = 2'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i] && (!win_ok ||
          {prio_hi_ff[i/2], prio_lo_ff[i/2]} >= win_lvl)) begin
        win_ok  = 1'b1;
        win_idx = 4'(i);
        win_lvl = {prio_hi_ff[i/2], prio_lo_ff[i/2]};
      end
    end
  end

  // Zero means idle, otherwise level plus one
  always_comb begin
    cur_lvl = 3'h0;
    for (int k = 0; k < 4; k++) begin
      if (insvc_ff[k]) begin
        cur_lvl = 3'(k + 1);
      end
    end
  end

  wire higher = ({1'b0, win_lvl} + 3'h1) > cur_lvl;
  wire [3:0] top_bit = (cur_lvl == 3'h0) ? 4'h0 :
                       4'h1 << (cur_lvl - 3'h1);

  // Poll only at the end of an instruction's last machine cycle;
  // a control write in that very cycle blocks as well
  wire poll_ok = mc_end_w & LAST_CYCLE & ~RETURN_FROM_INTERRUPT_EXEC &
                 ~blk_ff & ~wr_ctl;
  assign grant = poll_ok & win_ok & higher;
  assign wk_go = poll_ok & ~grant & cap_ff[NSRC] & gen_en;
  wire return_from_interrupt_go = mc_end_w & LAST_CYCLE & RETURN_FROM_INTERRUPT_EXEC;
  wire [3:0] nxt_insvc = grant ? (insvc_ff | (4'h1 << win_lvl)) :
                         return_from_interrupt_go ? (insvc_ff & ~top_bit) : insvc_ff;
  wire nxt_blk = wr_ctl | (blk_ff & ~(mc_end_w & LAST_CYCLE));

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      en_a_ff    <= pic_pkg::EN_RST;
      en_b_ff    <= pic_pkg::EN_RST[5:0];
      prio_lo_ff <= pic_pkg::PRIO_RST;
      prio_hi_ff <= pic_pkg::PRIO_RST;
      ctl_ff     <= pic_pkg::CTRL_RST;
    end else begin
      if (wr_ea) en_a_ff    <= WB_DAT_I[7:0];
      if (wr_eb) en_b_ff    <= WB_DAT_I[5:0];
      if (wr_pl) prio_lo_ff <= WB_DAT_I[5:0];
      if (wr_ph) prio_hi_ff <= WB_DAT_I[5:0];
      if (wr_ct) ctl_ff     <= WB_DAT_I[2:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      flg_ff   <= '0;
      cap_ff   <= '0;
      smp_ff   <= '1;
      insvc_ff <= 4'h0;
      blk_ff   <= 1'b0;
    end else begin
      flg_ff   <= nxt_flg;
      insvc_ff <= nxt_insvc;
      blk_ff   <= nxt_blk;
      if (state5_phase2_sample_point_w) begin
        cap_ff <= nxt_cap;
        smp_ff <= pin_s;
      end
    end
  end

  // Call request: core pushes the counter only, then jumps
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      hardware_long_call_ff <= 1'b0;
      vec_ff   <= 16'h0000;
    end else begin
      hardware_long_call_ff <= grant | wk_go;
      if (grant) vec_ff <= pic_pkg::VEC_TABLE[win_idx];
      else if (wk_go) vec_ff <= pic_pkg::VEC_WAKE;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ack_ff <= 1'b0;
      rd_ff  <= 32'h0000_0000;
    end else begin
      ack_ff <= req_on & ~ack_ff;
      if (req_on & ~ack_ff) rd_ff <= {24'h00_0000, rd_val};
    end
  end

  assign WB_ACK_O  = ack_ff;
  assign WB_DAT_O  = rd_ff;
  assign HARDWARE_LONG_CALL_REQ = hardware_long_call_ff;
  assign HARDWARE_LONG_CALL_VEC = vec_ff;
  assign MC_END    = mc_end_w;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  poll_block_a: assert property (
    hardware_long_call_ff |-> $past(mc_end_w && LAST_CYCLE && !RETURN_FROM_INTERRUPT_EXEC && !blk_ff))
    else $error("call issued outside an open poll");

  write_delay_a: assert property (
    wr_ctl |=> !hardware_long_call_ff [*8])
    else $error("call too soon after control write");

  preempt_level_a: assert property (
    hardware_long_call_ff && (vec_ff != pic_pkg::VEC_WAKE)
      |-> (insvc_ff ^ $past(insvc_ff)) > $past(insvc_ff))
    else $error("call not above running level");

  return_from_interrupt_clear_a: assert property (
    return_from_interrupt_go && (insvc_ff != 4'h0)
      |=> $countones(insvc_ff) == $countones($past(insvc_ff)) - 1)
    else $error("return did not drop one level");

  vector_form_a: assert property (
    hardware_long_call_ff |-> (vec_ff[2:0] == 3'h3) && (vec_ff[15:7] == 9'h000))
    else $error("vector outside table");

  edge_clear_a: assert property (
    hardware_long_call_ff && (vec_ff == pic_pkg::VEC_TABLE[7])
      |-> !flg_ff[pic_pkg::FLG_E4])
    else $error("edge flag left set after call");

  capture_point_a: assert property (
    !$stable(cap_ff) |-> $past(state5_phase2_sample_point_w))
    else $error("capture moved off sample point");

  level_follow_a: assert property (
    state5_phase2_sample_point_w && !it0 |=> flg_ff[pic_pkg::FLG_E0] == !$past(pin_s[0]))
    else $error("level flag not following pin");

  rise_edge_a: assert property (
    state5_phase2_sample_point_w && pin_s[2] && !smp_ff[2] |=> flg_ff[pic_pkg::FLG_E4])
    else $error("rising edge missed");

  reload_gate_a: assert property (
    state5_phase2_sample_point_w && !ctl_ff[pic_pkg::CTL_TIMER2_EXT_RELOAD_ENABLE] && !wr_fa
      |=> $stable(flg_ff[pic_pkg::FLG_TIMER2_EXT_RELOAD_FLAG]))
    else $error("reload flag set while disabled");

endmodule : pic_ctrl
`default_nettype wire

// file: testbench/pic_core_model.sv
// Core sequencer model: two-cycle instructions and return requests.
`timescale 1ns/1ns
`default_nettype none
module pic_core_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic mc_end,
  input  wire logic return_from_interrupt_req,
  output var  logic last_cycle,
  output var  logic return_from_interrupt_exec
);
  // ----------------------------------------------------------------
  // Instruction sequencing
  // ----------------------------------------------------------------
  logic half_ff;
  logic pend_ff;
  logic return_from_interrupt_ff;
  wire  instr_end = mc_end & half_ff;

  // Two cycles per instruction, so every other poll is mid-instruction
  assign last_cycle = half_ff;
  assign return_from_interrupt_exec  = return_from_interrupt_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_ff <= 1'b0;
      pend_ff <= 1'b0;
      return_from_interrupt_ff <= 1'b0;
    end else begin
      if (mc_end) begin
        half_ff <= ~half_ff;
      end
      if (return_from_interrupt_req) begin
        pend_ff <= 1'b1;
      end else if (instr_end) begin
        pend_ff <= 1'b0;
      end
      // A return occupies one whole instruction, then normal code again
      if (instr_end) begin
        return_from_interrupt_ff <= pend_ff;
      end
    end
  end
endmodule : pic_core_model
`default_nettype wire

// file: testbench/priority_interrupt_controller_tb.sv
// Self-checking bench for the priority interrupt controller.
`timescale 1ns/1ns
`default_nettype none
module priority_interrupt_controller_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        last;
  logic        return_from_interrupt_x;
  logic        return_from_interrupt_req = 1'b0;
  logic        p0 = 1'b1;
  logic        p1 = 1'b1;
  logic        p4 = 1'b1;
  logic        p2x = 1'b1;
  logic [7:0]  evt = 8'h00;
  logic        call;
  logic [15:0] vec;
  logic        mcend;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc_cnt = 0;
  logic [15:0] vtab [0:7] = '{16'h000B, 16'h001B, 16'h002B, 16'h0023,
                              16'h0023, 16'h0043, 16'h0053, 16'h007B};
  logic [15:0] ftab [0:7] = '{16'h0000, 16'h0000, 16'h0040, 16'h0010,
                              16'h0020, 16'h0100, 16'h0000, 16'h0000};

  always #2 clock = ~clock;

  pic_ctrl uut (
    .CLOCK(clock), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .LAST_CYCLE(last),
    .RETURN_FROM_INTERRUPT_EXEC(return_from_interrupt_x), .EXT0_PIN(p0), .EXT1_PIN(p1), .EXT4_PIN(p4),
    .EXT5_PIN(p4), .EXT6_PIN(p4), .TIMER2_RELOAD_TRIGGER_PIN_PIN(p2x),
    .TMR0_OVF(evt[0]), .TMR1_OVF(evt[1]), .TMR2_OVF(evt[2]),
    .SER_RX_DONE(evt[3]), .SER_TX_DONE(evt[4]), .ADC_DONE(evt[5]),
    .EXT3_EVT(evt[6]), .WAKE_EVT(evt[7]), .HARDWARE_LONG_CALL_REQ(call),
    .HARDWARE_LONG_CALL_VEC(vec), .MC_END(mcend));

  pic_core_model core (
    .clk(clock), .rst_n(rst_n), .mc_end(mcend), .return_from_interrupt_req(return_from_interrupt_req),
    .last_cycle(last), .return_from_interrupt_exec(return_from_interrupt_x));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // Classic cycle: hold the request until ack is sampled high;
  // a slave that never answers is caught by the run ceiling
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [7:0] d, output logic [31:0] r);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clock);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 8'h00, r);
    check(nm, e, r);
  endtask : rdc

  task automatic pulse(input logic [7:0] m);
    @(posedge clock);
    evt <= m;
    @(posedge clock);
    evt <= 8'h00;
  endtask : pulse

  task automatic wcall(input logic [15:0] e);
    logic [15:0] g;
    int n;
    g = 'x;
    n = 0;
    while (n < 400) begin
      @(posedge clock);
      n++;
      if (call === 1'b1) begin
        g = vec;
        n = 400;
      end
    end
    check("vector", {16'h0, e}, {16'h0, g});
  endtask : wcall

  task automatic nocall(input int c);
    logic s;
    s = 1'b0;
    repeat (c) begin
      @(posedge clock);
      if (call === 1'b1) s = 1'b1;
    end
    check("no call", 32'h0, {31'h0, s});
  endtask : nocall

  task automatic return_from_interrupt();
    int n;
    n = 0;
    @(posedge clock);
    return_from_interrupt_req <= 1'b1;
    @(posedge clock);
    return_from_interrupt_req <= 1'b0;
    while (return_from_interrupt_x !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    while (return_from_interrupt_x !== 1'b0 && n < 200) begin
      @(posedge clock);
      n++;
    end
  endtask : return_from_interrupt

  // Ceiling well above the roughly 2000 cycles the sequence needs
  always @(posedge clock) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      miscompares++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rdc("en_a", pic_pkg::OFS_EN_A, 32'h0);
    rdc("prio_hi", pic_pkg::OFS_PRIO_HI, 32'h0);
    rdc("status", pic_pkg::OFS_STATUS, 32'h0);
    wr(pic_pkg::OFS_PRIO_LO, 8'h15);
    rdc("prio_lo", pic_pkg::OFS_PRIO_LO, 32'h15);
    rdc("unmapped", 8'h20, 32'h0);
    wr(pic_pkg::OFS_PRIO_LO, 8'h00);
    wr(pic_pkg::OFS_EN_A, 8'hBA);
    wr(pic_pkg::OFS_EN_B, 8'h07);
    for (int k = 0; k < 8; k++) begin
      pulse(8'h01 << k);
      wcall(vtab[k]);
      rdc("flag_a", pic_pkg::OFS_FLAG_A, {24'h0, ftab[k][7:0]});
      rdc("flag_b", pic_pkg::OFS_FLAG_B, {24'h0, ftab[k][15:8]});
      wr(pic_pkg::OFS_FLAG_A, 8'h00);
      wr(pic_pkg::OFS_FLAG_B, 8'h00);
      return_from_interrupt();
    end
    wr(pic_pkg::OFS_FLAG_B, 8'h02);
    wcall(16'h004B);
    return_from_interrupt();
    // Equal level waits; a cleared flag is not remembered
    pulse(8'h01);
    wcall(16'h000B);
    pulse(8'h02);
    nocall(60);
    rdc("status", pic_pkg::OFS_STATUS, 32'h1);
    wr(pic_pkg::OFS_FLAG_A, 8'h00);
    return_from_interrupt();
    nocall(60);
    // Higher level preempts a running routine
    wr(pic_pkg::OFS_PRIO_LO, 8'h01);
    pulse(8'h01);
    wcall(16'h000B);
    pulse(8'h20);
    wcall(16'h0043);
    rdc("status", pic_pkg::OFS_STATUS, 32'h3);
    wr(pic_pkg::OFS_FLAG_B, 8'h00);
    return_from_interrupt();
    rdc("status", pic_pkg::OFS_STATUS, 32'h1);
    return_from_interrupt();
    rdc("status", pic_pkg::OFS_STATUS, 32'h0);
    // Simultaneous requests: level first, then polling order
    wr(pic_pkg::OFS_PRIO_HI, 8'h08);
    wr(pic_pkg::OFS_PRIO_LO, 8'h08);
    pulse(8'h23);
    wcall(16'h001B);
    return_from_interrupt();
    wcall(16'h0043);
    wr(pic_pkg::OFS_FLAG_B, 8'h00);
    return_from_interrupt();
    wcall(16'h000B);
    return_from_interrupt();
    wr(pic_pkg::OFS_PRIO_HI, 8'h00);
    wr(pic_pkg::OFS_PRIO_LO, 8'h00);
    // External 0 falling edge, held low past one machine cycle
    wr(pic_pkg::OFS_CTRL, 8'h01);
    wr(pic_pkg::OFS_EN_A, 8'h81);
    @(posedge clock);
    p0 <= 1'b0;
    wcall(16'h0003);
    rdc("flag_a", pic_pkg::OFS_FLAG_A, 32'h0);
    p0 <= 1'b1;
    return_from_interrupt();
    // External 1 low level, released before the return
    wr(pic_pkg::OFS_CTRL, 8'h00);
    wr(pic_pkg::OFS_EN_A, 8'h84);
    @(posedge clock);
    p1 <= 1'b0;
    wcall(16'h0013);
    rdc("flag_a", pic_pkg::OFS_FLAG_A, 32'h2);
    p1 <= 1'b1;
    return_from_interrupt();
    nocall(48);
    // External 4 ignores the falling edge
    wr(pic_pkg::OFS_EN_B, 8'h08);
    @(posedge clock);
    p4 <= 1'b0;
    nocall(48);
    p4 <= 1'b1;
    wcall(16'h005B);
    rdc("flag_b", pic_pkg::OFS_FLAG_B, 32'h30);
    return_from_interrupt();
    // Reload trigger falls: ignored until the enable bit is set
    wr(pic_pkg::OFS_EN_A, 8'hA0);
    p2x <= 1'b0;
    nocall(48);
    p2x <= 1'b1;
    nocall(24);
    wr(pic_pkg::OFS_CTRL, 8'h04);
    p2x <= 1'b0;
    wcall(16'h002B);
    rdc("flag_a", pic_pkg::OFS_FLAG_A, 32'h80);
    wr(pic_pkg::OFS_FLAG_A, 8'h00);
    p2x <= 1'b1;
    return_from_interrupt();
    results();
  end
endmodule : priority_interrupt_controller_tb
`default_nettype wire
